// ---- rtl/mol_limiter.v ----
// Motor overload current limiter with register port.
// Assumes the current sample in mA arrives on the same clock with a valid
// pulse once per control cycle.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "mol_defs.vh"
module mol_limiter
(
   input wire clk_i,
   input wire sys_rst_i,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire [31:0] current_i,
   input wire sample_i,
   output reg [31:0] applied_current_limit_o,
   output reg active_o,
   output reg clamp_o,
   output reg irq_o
);
   reg [31:0] max_motor;
   reg [31:0] rated;
   reg [31:0] max_permille;
   reg [31:0] peak_time_allowance;
   reg [31:0] submode;
   reg [63:0] overload_energy_limit;
   reg [63:0] accumulated_overload_value;
   reg [31:0] applied_current_limit;
   reg active;
   reg clamp;
   reg [`MOL_IRQ_W-1:0] irq_stat;
   reg [`MOL_IRQ_W-1:0] irq_mask;
   reg [31:0] peak_excess;
   reg [31:0] excess;
   reg [31:0] deficit;
   reg cond_ok;
   reg [63:0] next_accum;
   reg next_clamp;
   reg [31:0] next_limit;
   reg [`MOL_IRQ_W-1:0] irq_set;
   reg [`MOL_IRQ_W-1:0] irq_clear;
   wire [63:0] scaled_prod;
   wire [63:0] max_raw;
   wire [31:0] max_cur;
   wire [31:0] peak_cur;
   wire [63:0] exc_sq;
   wire [63:0] def_sq;
   wire [63:0] dif_sq;
   wire [95:0] lim_full;
   wire [63:0] lim_prod;
   wire next_active;
   wire [`MOL_IRQ_W-1:0] events;
   wire stat_wr;
   wire [31:0] thr_view;
   wire [31:0] acc_view;

   // Max current in mA: rated * permille / 1000
   assign scaled_prod = {32'h0000_0000, rated} * {32'h0000_0000, max_permille};
   assign max_raw = scaled_prod / 64'h0000_0000_0000_03E8;
   assign max_cur = max_raw[31:0];
   // Peak never above motor maximum
   assign peak_cur = (max_cur > max_motor) ? max_motor : max_cur;

   always @*
   begin
      cond_ok = 1'b0;
      peak_excess = 32'h0000_0000;
      if ((peak_cur > rated) && (peak_time_allowance != 32'h0000_0000))
      begin
         // Armed only with headroom above rated and a time budget
         cond_ok = 1'b1;
         peak_excess = peak_cur - rated;
      end
   end

   assign next_active = submode[0] && cond_ok;

   always @*
   begin
      excess = 32'h0000_0000;
      deficit = 32'h0000_0000;
      if (current_i > rated)
      begin
         excess = current_i - rated;
      end
      else
      begin
         deficit = rated - current_i;
      end
   end

   mol_square #(.W(32)) exc_square_inst
   (
      .value_i(excess),
      .square_o(exc_sq)
   );

   mol_square #(.W(32)) def_square_inst
   (
      .value_i(deficit),
      .square_o(def_sq)
   );

   mol_square #(.W(32)) dif_square_inst
   (
      .value_i(peak_excess),
      .square_o(dif_sq)
   );

   // Limit in (mA excess)^2 per sample; wraps past 64 bits, a user limit
   assign lim_full = {32'h0000_0000, dif_sq}
      * {64'h0000_0000_0000_0000, peak_time_allowance};
   assign lim_prod = lim_full[63:0];

   // Add squared excess per sample, or decay toward zero below rated
   always @*
   begin
      if (exc_sq != 64'h0000_0000_0000_0000)
      begin
         next_accum = accumulated_overload_value + exc_sq;
      end
      else if (accumulated_overload_value > def_sq)
      begin
         next_accum = accumulated_overload_value - def_sq;
      end
      else
      begin
         next_accum = 64'h0000_0000_0000_0000;
      end
   end

   // Clamp holds until the accumulation falls below the limit
   always @*
   begin
      next_clamp = 1'b0;
      if (next_accum >= overload_energy_limit)
      begin
         next_clamp = 1'b1;
      end
   end

   assign events = {next_active & ~active, ~next_clamp & clamp, next_clamp & ~clamp};
   assign stat_wr = wr_i && (addr_i == `MOL_A_IRQ_STAT);

   always @*
   begin
      irq_set = {events[`MOL_IRQ_ACTIVE], 2'b00};
      irq_clear = {`MOL_IRQ_W{1'b0}};
      if (active && next_active && sample_i)
      begin
         // Clamp edges only count on accumulation steps
         irq_set = events;
      end
      if (stat_wr)
      begin
         irq_clear = wdata_i[`MOL_IRQ_W-1:0];
      end
   end

   always @*
   begin
      if (!next_active || !active)
      begin
         next_limit = next_active ? peak_cur : max_motor;
      end
      else if (sample_i)
      begin
         next_limit = next_clamp ? rated : peak_cur;
      end
      else
      begin
         next_limit = clamp ? rated : peak_cur;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         max_motor <= `MOL_RST_MAX_MOTOR;
         rated <= `MOL_RST_RATED;
         max_permille <= `MOL_RST_PERMILLE;
         peak_time_allowance <= `MOL_RST_PEAK_MS;
         submode <= 32'h0000_0000;
         irq_mask <= {`MOL_IRQ_W{1'b0}};
      end
      else if (wr_i)
      begin
         case (addr_i)
            `MOL_A_MAX_MOTOR:
            begin
               max_motor <= wdata_i;
            end
            `MOL_A_RATED:
            begin
               rated <= wdata_i;
            end
            `MOL_A_MAX_PERMILLE:
            begin
               max_permille <= wdata_i;
            end
            `MOL_A_PEAK_MS:
            begin
               peak_time_allowance <= wdata_i;
            end
            `MOL_A_SUBMODE:
            begin
               submode <= wdata_i;
            end
            `MOL_A_IRQ_MASK:
            begin
               irq_mask <= wdata_i[`MOL_IRQ_W-1:0];
            end
            default:
            begin
            end
         endcase
      end
   end

   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         active <= 1'b0;
         clamp <= 1'b0;
         overload_energy_limit <= 64'h0000_0000_0000_0000;
         accumulated_overload_value <= 64'h0000_0000_0000_0000;
         applied_current_limit <= `MOL_RST_MAX_MOTOR;
      end
      else
      begin
         active <= next_active;
         overload_energy_limit <= lim_prod;
         applied_current_limit <= next_limit;
         if (!next_active || !active)
         begin
            // Fresh start on activation, idle while inactive
            accumulated_overload_value <= 64'h0000_0000_0000_0000;
            clamp <= 1'b0;
         end
         else if (sample_i)
         begin
            // One accumulation step per control cycle
            accumulated_overload_value <= next_accum;
            clamp <= next_clamp;
         end
      end
   end

   // Set wins over write-one-to-clear in the same cycle
   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         irq_stat <= {`MOL_IRQ_W{1'b0}};
      end
      else
      begin
         irq_stat <= (irq_stat & ~irq_clear) | irq_set;
      end
   end

   // Ten bits dropped: about /1000, cheaper than a divider
   assign thr_view = overload_energy_limit[41:10];
   assign acc_view = accumulated_overload_value[41:10];

   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         applied_current_limit_o <= `MOL_RST_MAX_MOTOR;
         active_o <= 1'b0;
         clamp_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         applied_current_limit_o <= applied_current_limit;
         active_o <= active;
         clamp_o <= clamp;
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rdata_o <= 32'h0000_0000;
      end
      else
      begin
         rdata_o <= 32'h0000_0000;
         if (rd_i)
         begin
            case (addr_i)
               `MOL_A_MAX_MOTOR:
               begin
                  rdata_o <= max_motor;
               end
               `MOL_A_RATED:
               begin
                  rdata_o <= rated;
               end
               `MOL_A_MAX_PERMILLE:
               begin
                  rdata_o <= max_permille;
               end
               `MOL_A_PEAK_MS:
               begin
                  rdata_o <= peak_time_allowance;
               end
               `MOL_A_THRESHOLD:
               begin
                  rdata_o <= thr_view;
               end
               `MOL_A_ACCUM:
               begin
                  rdata_o <= acc_view;
               end
               `MOL_A_LIMIT:
               begin
                  rdata_o <= applied_current_limit;
               end
               `MOL_A_STATUS:
               begin
                  rdata_o <= {31'h0000_0000, active};
               end
               `MOL_A_SUBMODE:
               begin
                  rdata_o <= submode;
               end
               `MOL_A_IRQ_STAT:
               begin
                  rdata_o <= {29'h0000_0000, irq_stat};
               end
               `MOL_A_IRQ_MASK:
               begin
                  rdata_o <= {29'h0000_0000, irq_mask};
               end
               default:
               begin
                  rdata_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end
endmodule

// Unsigned square at full width, no overflow
module mol_square
#(
   parameter W = 32
)
(
   input wire [W-1:0] value_i,
   output wire [2*W-1:0] square_o
);
   assign square_o = {{W{1'b0}}, value_i} * {{W{1'b0}}, value_i};
endmodule

// ---- common/mol_defs.vh ----
// Constants for the motor overload current limiter.
// Assumes inclusion by the limiter design file, the port checker and the bench.
`ifndef MOL_DEFS_VH
`define MOL_DEFS_VH
`define MOL_A_MAX_MOTOR 4'h0
`define MOL_A_RATED 4'h1
`define MOL_A_MAX_PERMILLE 4'h2
`define MOL_A_PEAK_MS 4'h3
`define MOL_A_THRESHOLD 4'h4
`define MOL_A_ACCUM 4'h5
`define MOL_A_LIMIT 4'h6
`define MOL_A_STATUS 4'h7
`define MOL_A_SUBMODE 4'h8
`define MOL_A_IRQ_STAT 4'h9
`define MOL_A_IRQ_MASK 4'hA
`define MOL_RST_MAX_MOTOR 32'h0000_0BB8
`define MOL_RST_RATED 32'h0000_07D0
`define MOL_RST_PERMILLE 32'h0000_03E8
`define MOL_RST_PEAK_MS 32'h0000_0000
`define MOL_CLK_KHZ 200000
`define MOL_MS_CYCLES 200000
`define MOL_IRQ_CLAMP 0
`define MOL_IRQ_RELEASE 1
`define MOL_IRQ_ACTIVE 2
`define MOL_IRQ_W 3
`endif

// ---- verification/mol_limiter_checker.sv ----
// Port assertions for the overload limiter.
// Bound to mol_limiter; sees its ports only.
`timescale 1ns/1ps
`include "mol_defs.vh"
module mol_limiter_checker
(
   input wire clk_i,
   input wire sys_rst_i,
   input wire [3:0] addr_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire sample_i,
   input wire active_o,
   input wire clamp_o,
   input wire irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_clamp_step; $rose(clamp_o) |-> $past(sample_i, 2); endproperty
   a_clamp_step: assert property (p_clamp_step) else $error("clamp rose off a step");
   property p_act_clear; $rose(active_o) |-> !clamp_o; endproperty
   a_act_clear: assert property (p_act_clear) else $error("clamp set on activation");
   property p_off_free; !active_o [*2] |-> !clamp_o; endproperty
   a_off_free: assert property (p_off_free) else $error("clamp while inactive");
   property p_hold; !$past(sample_i, 2) && !$past(wr_i, 3) && $stable(active_o)
      |-> $stable(clamp_o);
   endproperty
   a_hold: assert property (p_hold) else $error("clamp moved without a step");
   property p_act_cfg; $changed(active_o) |-> $past(wr_i, 3); endproperty
   a_act_cfg: assert property (p_act_cfg) else $error("active moved without a write");
   property p_stat; rd_i && addr_i == `MOL_A_STATUS |=> rdata_o[0] == active_o; endproperty
   a_stat: assert property (p_stat) else $error("status bit differs from active");
   property p_stat_hi; rd_i && addr_i == `MOL_A_STATUS |=> rdata_o[31:1] == 31'h0000_0000;
   endproperty
   a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
   property p_rel; $fell(clamp_o) |-> $past(sample_i, 2) || $past(wr_i, 3);
   endproperty
   a_rel: assert property (p_rel) else $error("clamp released off a step");
   c_clamp: cover property ($rose(clamp_o));
   c_release: cover property ($fell(clamp_o));
   c_irq: cover property ($rose(irq_o));
endmodule
bind mol_limiter mol_limiter_checker mol_limiter_checker_inst (.clk_i, .sys_rst_i, .addr_i,
   .wr_i, .rd_i, .rdata_o, .sample_i, .active_o, .clamp_o, .irq_o);

// ---- verification/mol_drive_model.sv ----
// Current loop stand-in: follows demand, capped by the applied limit.
// Assumes one clock; current tracks every cycle, sample pulses once every fourth cycle.
`timescale 1ns/1ps
module mol_drive_model
(
   input wire clk_i,
   input wire [31:0] demand_i,
   input wire [31:0] limit_i,
   output reg [31:0] current_o = 32'h0000_0000,
   output reg sample_o = 1'b0
);
   reg [1:0] div = 2'h0;
   always @(posedge clk_i)
   begin
      div <= div + 2'h1;
      sample_o <= (div == 2'h3);
      current_o <= (demand_i > limit_i) ? limit_i : demand_i;
   end
endmodule

// ---- verification/test_motor_overload_current_limiter.sv ----
// Self-checking bench for the overload limiter.
// Drives the register port; the drive model closes the current loop.
`timescale 1ns/1ps
`include "mol_defs.vh"
module test_motor_overload_current_limiter;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] demand = 32'h0000_0000;
   wire [31:0] rdata_o, current_i, limit;
   wire sample_i, active_o, clamp_o, irq_o;
   int failures = 0;
   int n_compared = 0;
   logic [35:0] rows [7] = '{{`MOL_A_MAX_MOTOR, `MOL_RST_MAX_MOTOR}, {`MOL_A_RATED, `MOL_RST_RATED},
      {`MOL_A_MAX_PERMILLE, `MOL_RST_PERMILLE}, {`MOL_A_PEAK_MS, `MOL_RST_PEAK_MS},
      {`MOL_A_STATUS, 32'h0000_0000}, {`MOL_A_LIMIT, `MOL_RST_MAX_MOTOR}, {4'hB, 32'h0000_0000}};
   always #2.5 clk_i = ~clk_i;
   mol_limiter mol_limiter_inst (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .current_i, .sample_i, .applied_current_limit_o(limit), .active_o, .clamp_o, .irq_o);
   mol_drive_model mol_drive_model_inst (.clk_i, .demand_i(demand), .limit_i(limit),
      .current_o(current_i), .sample_o(sample_i));
   task chk(string n, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) failures++;
      if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
   endtask
   task wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(logic [3:0] a, logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", rdata_o, e);
   endtask
   // Decay speed is open, so the wait is generous
   task wait_clamp(logic v);
      for (int i = 0; i < 2000 && clamp_o !== v; i++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      chk("clamp", {31'h0, clamp_o}, {31'h0, v});
   endtask
   task summarize;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #100000 failures++;
      summarize;
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1 chk("limit", limit, `MOL_RST_MAX_MOTOR);
      for (int i = 0; i < 7; i++) rd(rows[i][35:32], rows[i][31:0]);
      wr(`MOL_A_RATED, 32'h0000_000A);
      wr(`MOL_A_MAX_PERMILLE, 32'h0000_07D0);
      wr(`MOL_A_PEAK_MS, 32'h0000_0002);
      wr(`MOL_A_MAX_MOTOR, 32'h0000_000F);
      wr(`MOL_A_IRQ_MASK, 32'h0000_0007);
      rd(`MOL_A_STATUS, 32'h0000_0000);
      wr(`MOL_A_SUBMODE, 32'h0000_0001);
      rd(`MOL_A_STATUS, 32'h0000_0001);
      chk("limit", limit, 32'h0000_000F);
      demand <= 32'h0000_0014;
      wait_clamp(1'b1);
      chk("limit", limit, 32'h0000_000A);
      chk("irq", {31'h0, irq_o}, 32'h0000_0001);
      rd(`MOL_A_THRESHOLD, 32'h0000_0000);
      rd(`MOL_A_ACCUM, 32'h0000_0000);
      rd(`MOL_A_LIMIT, 32'h0000_000A);
      demand <= 32'h0000_0000;
      wait_clamp(1'b0);
      chk("limit", limit, 32'h0000_000F);
      rd(`MOL_A_IRQ_STAT, 32'h0000_0007);
      wr(`MOL_A_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge clk_i);
      chk("irq", {31'h0, irq_o}, 32'h0000_0000);
      wr(`MOL_A_PEAK_MS, 32'h0000_0000);
      rd(`MOL_A_STATUS, 32'h0000_0000);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1 chk("limit", limit, `MOL_RST_MAX_MOTOR);
      rd(`MOL_A_SUBMODE, 32'h0000_0000);
      rd(`MOL_A_RATED, `MOL_RST_RATED);
      summarize;
   end
endmodule
